// file: src/conv_pkg.sv
package conv_pkg;
	localparam logic [3:0] OFS_FIXED_REF  = 4'h0;
	localparam logic [3:0] OFS_CONV_CTRL0 = 4'h4;
	localparam logic [3:0] OFS_CONV_CTRL1 = 4'h8;
	localparam logic [3:0] OFS_RESULT_HI  = 4'hC;
	localparam logic [3:0] OFS_RESULT_LO  = 4'h0;
	localparam logic [4:0] OFS_RESULT_LO_FULL = 5'h10;
	localparam logic [4:0] OFS_IRQ        = 5'h14;
	localparam int         FR_EN_BIT      = 7;
	localparam int         FR_RDY_BIT     = 6;
	localparam int         C0_ON_BIT      = 0;
	localparam int         C0_GO_BIT      = 1;
	localparam int         C0_CHS_LSB     = 2;
	localparam int         C1_NREF_BIT    = 2;
	localparam int         STAB_NS        = 25000;
	localparam int         CLK_NS         = 20;
	localparam int         STAB_CYC       = (STAB_NS + CLK_NS - 1) / CLK_NS;
	localparam int         TAD_CYC        = 4;
	localparam int         HALF_TAD_CYC   = TAD_CYC / 2;
	localparam logic [7:0] FR_RESET       = 8'h00;
	localparam logic [1:0] GAIN_OFF       = 2'h0;
	localparam logic [1:0] GAIN_1X        = 2'h1;
	localparam logic [1:0] GAIN_2X        = 2'h2;
	localparam logic [1:0] GAIN_4X        = 2'h3;
	localparam logic [4:0] CH_DAC         = 5'h1E;
	localparam logic [4:0] CH_FIXED_REF   = 5'h1F;
	localparam logic [4:0] CH_PIN_LAST    = 5'h0B;
	localparam logic [1:0] PREF_PIN       = 2'h0;
	localparam logic [1:0] PREF_SUPPLY    = 2'h1;
	localparam logic [1:0] PREF_FR_LOW    = 2'h2;
	localparam logic [1:0] PREF_FR_HIGH   = 2'h3;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {
		CV_IDLE   = 2'b00,
		CV_SAMPLE = 2'b01,
		CV_BITS   = 2'b10
	} conv_state_t;
endpackage : conv_pkg

// file: src/sar_step.sv
`timescale 1ns/1ps
`default_nettype none
// one successive-approximation decision: keep or drop the trial bit
module sar_step (
	// trial
	input  wire logic [9:0] code_i,
	input  wire logic [9:0] bit_i,
	input  wire logic       cmp_high_i,
	// decision
	output logic      [9:0] code_o
);
	assign code_o = cmp_high_i ? code_i : (code_i & ~bit_i);
endmodule : sar_step
`default_nettype wire

// file: src/adc_ref_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ref_ctrl #(
	parameter int STAB_CYCLES = conv_pkg::STAB_CYC,
	parameter bit LOW_VOLTAGE = 1'b0
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// axi4-lite write
	input  wire logic [4:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	// axi4-lite read
	input  wire logic [4:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	// analog front end
	input  wire logic        cmp_high_i,
	output logic             ref_on_o,
	output logic [1:0]       cmp_dac_gain_o,
	output logic [1:0]       adc_gain_o,
	output logic [4:0]       mux_sel_o,
	output logic             sample_o,
	output logic [1:0]       pos_ref_o,
	output logic             neg_ref_gnd_o,
	output logic [9:0]       dac_trial_o,
	// completion
	output logic             conv_irq_o
);
	logic [7:0]  fixed_ref_r;
	logic [7:0]  conv_ctrl0_r;
	logic [7:0]  conv_ctrl1_r;
	logic [9:0]  result_r;
	logic        irq_flag_r;
	logic [15:0] stab_cnt_r;
	logic        ready_r;
	logic        en_d_r;
	conv_pkg::conv_state_t state_r;
	logic [7:0]  tcnt_r;
	logic [9:0]  code_r;
	logic [9:0]  bit_r;
	logic [9:0]  code_nxt;
	logic        done_evt;
	logic [7:0]  busy_cnt_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [4:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        wr_go;
	logic        go_write_one;
	logic        go_write_zero;
	logic [31:0] rd_val;
	logic        rd_ok;

	// write channel: address and data taken in either order, then one response
	assign wr_go = aw_hold_r && w_hold_r && !bvalid_o;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= 5'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			awready_o <= 1'b0;
			wready_o  <= 1'b0;
			bvalid_o  <= 1'b0;
			bresp_o   <= conv_pkg::RESP_OKAY;
		end else begin
			awready_o <= !aw_hold_r && !awready_o && !(awvalid_i && awready_o);
			wready_o  <= !w_hold_r && !wready_o && !(wvalid_i && wready_o);
			if (awvalid_i && awready_o) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= awaddr_i;
				awready_o <= 1'b0;
			end
			if (wvalid_i && wready_o) begin
				w_hold_r <= 1'b1;
				w_data_r <= wdata_i;
				w_strb_r <= wstrb_i;
				wready_o <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_o  <= 1'b1;
				bresp_o   <= (aw_addr_r[1:0] == 2'h0 && aw_addr_r <= conv_pkg::OFS_IRQ)
					? conv_pkg::RESP_OKAY : conv_pkg::RESP_SLVERR;
			end else if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	assign go_write_one  = wr_go && w_strb_r[0] && aw_addr_r == {1'b0, conv_pkg::OFS_CONV_CTRL0}
		&& w_data_r[conv_pkg::C0_GO_BIT];
	assign go_write_zero = wr_go && w_strb_r[0] && aw_addr_r == {1'b0, conv_pkg::OFS_CONV_CTRL0}
		&& !w_data_r[conv_pkg::C0_GO_BIT];

	// reference control register; reserved bits never stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fixed_ref_r <= conv_pkg::FR_RESET;
		end else if (wr_go && w_strb_r[0] && aw_addr_r == {1'b0, conv_pkg::OFS_FIXED_REF}) begin
			fixed_ref_r <= {w_data_r[7], 3'h0, w_data_r[3:0]};
		end
	end

	// control registers; the go bit lives in the conversion machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_ctrl0_r <= 8'h00;
			conv_ctrl1_r <= 8'h00;
		end else if (wr_go && w_strb_r[0]) begin
			if (aw_addr_r == {1'b0, conv_pkg::OFS_CONV_CTRL0}) begin
				conv_ctrl0_r <= {1'b0, w_data_r[6:2], 1'b0, w_data_r[0]};
			end
			if (aw_addr_r == {1'b0, conv_pkg::OFS_CONV_CTRL1}) begin
				// low-voltage parts cannot take the high fixed level, so it falls back to supply
				if (LOW_VOLTAGE && w_data_r[1:0] == conv_pkg::PREF_FR_HIGH) begin
					conv_ctrl1_r <= {5'h00, w_data_r[2], conv_pkg::PREF_SUPPLY};
				end else begin
					conv_ctrl1_r <= {5'h00, w_data_r[2:0]};
				end
			end
		end
	end

	// stabilization counter restarts on each enable edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_d_r     <= 1'b0;
			stab_cnt_r <= 16'h0000;
			ready_r    <= 1'b0;
		end else begin
			en_d_r <= fixed_ref_r[conv_pkg::FR_EN_BIT];
			if (!fixed_ref_r[conv_pkg::FR_EN_BIT]) begin
				stab_cnt_r <= 16'h0000;
				ready_r    <= 1'b0;
			end else if (!en_d_r) begin
				stab_cnt_r <= 16'h0000;
				ready_r    <= 1'b0;
			end else if (stab_cnt_r == 16'(STAB_CYCLES - 1)) begin
				ready_r <= 1'b1;
			end else begin
				stab_cnt_r <= stab_cnt_r + 16'h0001;
			end
		end
	end

	AST_READY_AFTER_STAB: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ready_r) |-> $past(fixed_ref_r[7], STAB_CYCLES))
		else $error("ready rose before the reference settled");
	AST_READY_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		!fixed_ref_r[7] |=> !ready_r)
		else $error("ready stayed up with reference disabled");

	// conversion: one period sampling, ten full periods of bits, half a period finishing
	sar_step u_step (
		.code_i     (code_r),
		.bit_i      (bit_r),
		.cmp_high_i (cmp_high_i),
		.code_o     (code_nxt)
	);

	assign done_evt = state_r == conv_pkg::CV_BITS && tcnt_r == 8'h00 && bit_r == 10'h000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= conv_pkg::CV_IDLE;
			tcnt_r  <= 8'h00;
			code_r  <= 10'h000;
			bit_r   <= 10'h000;
		end else begin
			unique case (state_r)
				conv_pkg::CV_IDLE: begin
					// go is ignored while the converter is off, or turned off by the same write
					if (go_write_one && conv_ctrl0_r[conv_pkg::C0_ON_BIT] && w_data_r[conv_pkg::C0_ON_BIT]) begin
						state_r <= conv_pkg::CV_SAMPLE;
						tcnt_r  <= 8'(conv_pkg::TAD_CYC - 1);
					end
				end
				conv_pkg::CV_SAMPLE: begin
					if (go_write_zero) begin
						state_r <= conv_pkg::CV_IDLE;
					end else if (tcnt_r == 8'h00) begin
						state_r <= conv_pkg::CV_BITS;
						tcnt_r  <= 8'(conv_pkg::TAD_CYC - 1);
						code_r  <= 10'h200;
						bit_r   <= 10'h200;
					end else begin
						tcnt_r <= tcnt_r - 8'h01;
					end
				end
				conv_pkg::CV_BITS: begin
					if (go_write_zero || done_evt) begin
						state_r <= conv_pkg::CV_IDLE;
					end else if (tcnt_r == 8'h00) begin
						if (bit_r == 10'h001) begin
							tcnt_r <= 8'(conv_pkg::HALF_TAD_CYC - 1);
						end else begin
							tcnt_r <= 8'(conv_pkg::TAD_CYC - 1);
						end
						code_r <= code_nxt | (bit_r >> 1);
						bit_r  <= bit_r >> 1;
					end else begin
						tcnt_r <= tcnt_r - 8'h01;
					end
				end
				default: state_r <= conv_pkg::CV_IDLE;
			endcase
		end
	end

	// result pair: loaded on completion, or partial on abort during the bit phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_r <= 10'h000;
		end else if (done_evt) begin
			result_r <= code_r;
		end else if (go_write_zero && state_r == conv_pkg::CV_BITS) begin
			result_r <= code_r;
		end
	end

	// completion flag: set wins over a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_r <= 1'b0;
		end else if (done_evt) begin
			irq_flag_r <= 1'b1;
		end else if (wr_go && w_strb_r[0] && aw_addr_r == conv_pkg::OFS_IRQ && w_data_r[0]) begin
			irq_flag_r <= 1'b0;
		end
	end

	// assertion helper: cycles spent since the machine left idle
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r == conv_pkg::CV_IDLE) begin
			busy_cnt_r <= 8'h00;
		end else begin
			busy_cnt_r <= busy_cnt_r + 8'h01;
		end
	end

	AST_CONV_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
		done_evt |-> busy_cnt_r == 8'(conv_pkg::TAD_CYC * 11 + conv_pkg::HALF_TAD_CYC - 1))
		else $error("conversion did not take eleven and a half periods");
	AST_DONE_SETS_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
		done_evt |=> irq_flag_r && state_r == conv_pkg::CV_IDLE && result_r == $past(code_r))
		else $error("completion did not set flag, clear go and load result");
	AST_GO_NEEDS_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == conv_pkg::CV_IDLE && !conv_ctrl0_r[0]) |=> state_r == conv_pkg::CV_IDLE)
		else $error("conversion started with converter off");
	AST_TOTAL_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_r == conv_pkg::CV_SAMPLE) |-> ##[1:46] state_r == conv_pkg::CV_IDLE)
		else $error("conversion overran eleven and a half periods");

	// analog side outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_on_o       <= 1'b0;
			cmp_dac_gain_o <= conv_pkg::GAIN_OFF;
			adc_gain_o     <= conv_pkg::GAIN_OFF;
			mux_sel_o      <= 5'h00;
			sample_o       <= 1'b0;
			pos_ref_o      <= conv_pkg::PREF_PIN;
			neg_ref_gnd_o  <= 1'b0;
			dac_trial_o    <= 10'h000;
			conv_irq_o     <= 1'b0;
		end else begin
			ref_on_o       <= fixed_ref_r[conv_pkg::FR_EN_BIT];
			// gain codes pass straight to the amplifier: 00 off, 01/10/11 for 1x/2x/4x
			cmp_dac_gain_o <= fixed_ref_r[3:2];
			adc_gain_o     <= fixed_ref_r[1:0];
			// codes 0..11 pins, DAC and fixed reference codes; others leave mux open
			mux_sel_o      <= conv_ctrl0_r[6:2];
			sample_o       <= state_r == conv_pkg::CV_SAMPLE;
			pos_ref_o      <= conv_ctrl1_r[1:0];
			neg_ref_gnd_o  <= conv_ctrl1_r[conv_pkg::C1_NREF_BIT];
			dac_trial_o    <= code_r;
			conv_irq_o     <= irq_flag_r;
		end
	end

	AST_REF_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(fixed_ref_r[7]) |=> ##1 ref_on_o == $past(fixed_ref_r[7], 2))
		else $error("reference output did not follow enable");
	AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		fixed_ref_r[5:4] == 2'h0)
		else $error("reserved bits stored");
	AST_LV_NO_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		LOW_VOLTAGE |-> pos_ref_o != conv_pkg::PREF_FR_HIGH)
		else $error("high fixed level offered on low-voltage part");

	// read channel: one cycle to answer
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (araddr_i)
			{1'b0, conv_pkg::OFS_FIXED_REF}:  rd_val = {24'h0, fixed_ref_r[7], ready_r, 2'h0, fixed_ref_r[3:0]};
			{1'b0, conv_pkg::OFS_CONV_CTRL0}: rd_val = {24'h0, conv_ctrl0_r[7:2], state_r != conv_pkg::CV_IDLE,
				conv_ctrl0_r[0]};
			{1'b0, conv_pkg::OFS_CONV_CTRL1}: rd_val = {24'h0, conv_ctrl1_r};
			{1'b0, conv_pkg::OFS_RESULT_HI}:  rd_val = {30'h0, result_r[9:8]};
			conv_pkg::OFS_RESULT_LO_FULL:    rd_val = {24'h0, result_r[7:0]};
			conv_pkg::OFS_IRQ:               rd_val = {31'h0, irq_flag_r};
			default:                         rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arready_o <= 1'b0;
			rvalid_o  <= 1'b0;
			rdata_o   <= 32'h0000_0000;
			rresp_o   <= conv_pkg::RESP_OKAY;
		end else begin
			arready_o <= !rvalid_o && !arready_o;
			if (arvalid_i && arready_o) begin
				arready_o <= 1'b0;
				rvalid_o  <= 1'b1;
				rdata_o   <= rd_val;
				rresp_o   <= rd_ok ? conv_pkg::RESP_OKAY : conv_pkg::RESP_SLVERR;
			end else if (rvalid_o && rready_i) begin
				rvalid_o <= 1'b0;
			end
		end
	end
endmodule : adc_ref_ctrl
`default_nettype wire

// file: verification/adc_reference_channel_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_reference_channel_config_tb_top;
	localparam int         STAB  = 8;
	localparam logic [4:0] A_FR  = {1'b0, conv_pkg::OFS_FIXED_REF};
	localparam logic [4:0] A_C0  = {1'b0, conv_pkg::OFS_CONV_CTRL0};
	localparam logic [4:0] A_C1  = {1'b0, conv_pkg::OFS_CONV_CTRL1};
	localparam logic [4:0] A_HI  = {1'b0, conv_pkg::OFS_RESULT_HI};
	localparam logic [4:0] A_LO  = conv_pkg::OFS_RESULT_LO_FULL;
	localparam logic [4:0] A_IRQ = conv_pkg::OFS_IRQ;
	logic        clk_i      = 1'b0;
	logic        rst_i      = 1'b1;
	logic [4:0]  awaddr_i   = 5'h00;
	logic        awvalid_i  = 1'b0;
	logic [31:0] wdata_i    = 32'h00000000;
	logic        wvalid_i   = 1'b0;
	logic        bready_i   = 1'b0;
	logic [4:0]  araddr_i   = 5'h00;
	logic        arvalid_i  = 1'b0;
	logic        rready_i   = 1'b0;
	logic        cmp_high_i = 1'b0;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic        ref_on_o, sample_o, neg_ref_gnd_o, conv_irq_o;
	logic [1:0]  bresp_o, rresp_o, cmp_dac_gain_o, adc_gain_o, pos_ref_o;
	logic [31:0] rdata_o;
	logic [4:0]  mux_sel_o;
	logic [9:0]  dac_trial_o;
	logic [1:0]  pos_ref_lv;
	int          err_count  = 0;
	int          n_tests    = 0;

	always #10 clk_i = ~clk_i;

	adc_ref_ctrl #(.STAB_CYCLES(STAB), .LOW_VOLTAGE(1'b0)) dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
		.wdata_i(wdata_i), .wstrb_i(4'hF), .wvalid_i(wvalid_i), .wready_o(wready_o),
		.bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
		.araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
		.rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
		.cmp_high_i(cmp_high_i), .ref_on_o(ref_on_o), .cmp_dac_gain_o(cmp_dac_gain_o),
		.adc_gain_o(adc_gain_o), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
		.pos_ref_o(pos_ref_o), .neg_ref_gnd_o(neg_ref_gnd_o), .dac_trial_o(dac_trial_o),
		.conv_irq_o(conv_irq_o)
	);

	// low-voltage variant shares the bus; only its positive reference is watched
	adc_ref_ctrl #(.STAB_CYCLES(STAB), .LOW_VOLTAGE(1'b1)) dut_lv (
		.clk_i(clk_i), .rst_i(rst_i),
		.awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(),
		.wdata_i(wdata_i), .wstrb_i(4'hF), .wvalid_i(wvalid_i), .wready_o(),
		.bresp_o(), .bvalid_o(), .bready_i(bready_i),
		.araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(),
		.rdata_o(), .rresp_o(), .rvalid_o(), .rready_i(rready_i),
		.cmp_high_i(cmp_high_i), .ref_on_o(), .cmp_dac_gain_o(),
		.adc_gain_o(), .mux_sel_o(), .sample_o(),
		.pos_ref_o(pos_ref_lv), .neg_ref_gnd_o(), .dac_trial_o(),
		.conv_irq_o()
	);

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic timeout();
		err_count++;
		$display("[FAIL] wait limit expected 1 seen 0");
		complete_run();
	endtask : timeout

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// address and data offered together, each released once its ready is seen
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		awaddr_i  <= a;
		wdata_i   <= d;
		awvalid_i <= 1'b1;
		wvalid_i  <= 1'b1;
		bready_i  <= 1'b1;
		n = 0;
		forever begin
			@(posedge clk_i);
			n++;
			if (awready_o === 1'b1) awvalid_i <= 1'b0;
			if (wready_o === 1'b1) wvalid_i <= 1'b0;
			if (bvalid_o === 1'b1) break;
			if (n > 50) timeout();
		end
		r = bresp_o;
		bready_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr_i  <= a;
		arvalid_i <= 1'b1;
		rready_i  <= 1'b1;
		n = 0;
		forever begin
			@(posedge clk_i);
			n++;
			if (arready_o === 1'b1) arvalid_i <= 1'b0;
			if (rvalid_o === 1'b1) break;
			if (n > 50) timeout();
		end
		d = rdata_o;
		r = rresp_o;
		rready_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd

	task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(nm, d, exp);
		check("rresp", {30'h0, r}, {30'h0, conv_pkg::RESP_OKAY});
	endtask : rchk

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [4:0]  input_channel_select [4];
		int          cnt;
		input_channel_select = '{5'h00, conv_pkg::CH_PIN_LAST, conv_pkg::CH_DAC, conv_pkg::CH_FIXED_REF};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk("fixed_ref reset", A_FR, 32'h0);
		check("ref_on reset", {31'h0, ref_on_o}, 32'h0);
		// reserved bits written as zero, still must read zero
		wr(A_FR, 32'h0000008F, r);
		check("mapped bresp", {30'h0, r}, {30'h0, conv_pkg::RESP_OKAY});
		rchk("ready while settling", A_FR, 32'h0000008F);
		check("ref_on", {31'h0, ref_on_o}, 32'h1);
		repeat (STAB + 4) @(posedge clk_i);
		rchk("ready after settle", A_FR, 32'h000000CF);
		for (int i = 0; i < 4; i++) begin
			wr(A_FR, 32'h80 | (i << 2) | (3 - i), r);
			check("cmp gain", {30'h0, cmp_dac_gain_o}, i);
			check("adc gain", {30'h0, adc_gain_o}, 3 - i);
		end
		wr(A_FR, 32'h0, r);
		rchk("ready when off", A_FR, 32'h0);
		check("ref_off", {31'h0, ref_on_o}, 32'h0);
		wr(A_FR, 32'h80, r);
		rchk("ready restarts", A_FR, 32'h80);
		repeat (STAB + 4) @(posedge clk_i);
		rchk("ready again", A_FR, 32'hC0);
		for (int i = 0; i < 4; i++) begin
			wr(A_C0, {25'h0, input_channel_select[i], 2'b01}, r);
			check("mux sel", {27'h0, mux_sel_o}, {27'h0, input_channel_select[i]});
			rchk("ctrl0 readback", A_C0, {25'h0, input_channel_select[i], 2'b01});
		end
		for (int i = 0; i < 4; i++) begin
			wr(A_C1, 32'(i) | ((i & 1) << 2), r);
			check("pos ref", {30'h0, pos_ref_o}, i);
			check("neg ref gnd", {31'h0, neg_ref_gnd_o}, i & 1);
		end
		check("fixed high kept", {30'h0, pos_ref_o}, {30'h0, conv_pkg::PREF_FR_HIGH});
		check("lv pos ref", {30'h0, pos_ref_lv}, {30'h0, conv_pkg::PREF_SUPPLY});
		// two conversions: comparator always high, then always low
		for (int k = 0; k < 2; k++) begin
			cmp_high_i <= (k == 0);
			wr(A_C0, {25'h0, 5'h03, 2'b01}, r);
			repeat (4) @(posedge clk_i);
			wr(A_C0, {25'h0, 5'h03, 2'b11}, r);
			check("sampling", {31'h0, sample_o}, 32'h1);
			cnt = 0;
			while (conv_irq_o !== 1'b1) begin
				@(posedge clk_i);
				cnt++;
				if (cnt > 200) timeout();
			end
			// the go write lands two edges before cnt starts; the flag output adds one register
			check("conv time", cnt, 32'(conv_pkg::TAD_CYC * 11 + conv_pkg::HALF_TAD_CYC));
			check("trial code", {22'h0, dac_trial_o}, (k == 0) ? 32'h3FF : 32'h0);
			rchk("go cleared", A_C0, {25'h0, 5'h03, 2'b01});
			rchk("irq flag", A_IRQ, 32'h1);
			rchk("result hi", A_HI, (k == 0) ? 32'h3 : 32'h0);
			rchk("result lo", A_LO, (k == 0) ? 32'hFF : 32'h0);
			wr(A_IRQ, 32'h1, r);
			check("irq cleared", {31'h0, conv_irq_o}, 32'h0);
			rchk("irq flag clr", A_IRQ, 32'h0);
		end
		// abort in mid-conversion: busy drops and no completion is flagged later
		wr(A_C0, {25'h0, 5'h03, 2'b11}, r);
		repeat (10) @(posedge clk_i);
		wr(A_C0, {25'h0, 5'h03, 2'b01}, r);
		rchk("abort clears busy", A_C0, {25'h0, 5'h03, 2'b01});
		// go without the converter on is ignored: once while turning it off, once when off
		wr(A_C0, 32'h2, r);
		wr(A_C0, 32'h2, r);
		repeat (60) @(posedge clk_i);
		check("no start when off", {31'h0, conv_irq_o}, 32'h0);
		rchk("go stays low", A_C0, 32'h0);
		wr(5'h18, 32'h5A, r);
		check("unmapped bresp", {30'h0, r}, {30'h0, conv_pkg::RESP_SLVERR});
		rd(5'h18, d, r);
		check("unmapped rresp", {30'h0, r}, {30'h0, conv_pkg::RESP_SLVERR});
		check("unmapped rdata", d, 32'h0);
		complete_run();
	end
endmodule : adc_reference_channel_config_tb_top
`default_nettype wire
